// ---- logic/pcst_pkg.sv ----
// Purpose: Shared constants and types for the processor state block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Widths are fixed; no register bus offsets are needed.
package pcst_pkg;
   localparam int PC_W = 64;
   localparam int DATA_W = 64;
   localparam int REG_W = 5;
   localparam logic [63:0] PC_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] PC_STEP_16 = 64'h0000_0000_0000_0002;
   localparam logic [63:0] PC_STEP_32 = 64'h0000_0000_0000_0004;
   localparam logic ORDER_LITTLE = 1'h0;
   localparam logic ORDER_BIG = 1'h1;
   localparam logic ISA_STD32 = 1'h0;
   localparam logic ISA_COMP16 = 1'h1;

   typedef enum logic [2:0] {
      BR_IDLE = 3'b001,
      BR_PENDING = 3'b010,
      BR_SLOT = 3'b100
   } pcst_br_state_t;
endpackage : pcst_pkg

// ---- logic/pcst_link_flag.sv ----
// Purpose: Link reservation flag for linked load and conditional store.
// Assumes: Event inputs are one-cycle pulses in an instruction slot.
// Notes: A set in the same slot as a clearing event wins.
`timescale 1ns/1ps
`default_nettype none
module pcst_link_flag (
   input wire logic clk,
   input wire logic rst,
   input wire logic linked_load,
   input wire logic cond_store,
   input wire logic atomic_break,
   input wire logic exc_return,
   output logic flag,
   output logic store_ok
);
   logic flag_r;
   logic flag_nxt;

   always_comb begin
      flag_nxt = flag_r;
      if (atomic_break || exc_return || cond_store) begin
         flag_nxt = 1'b0;
      end
      if (linked_load) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag = flag_r;
   assign store_ok = cond_store & flag_r;
endmodule : pcst_link_flag
`default_nettype wire

// ---- logic/pcst_pc_next.sv ----
// Purpose: Next program counter computation.
// Assumes: Redirect has priority over explicit write and increment.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pcst_pc_next (
   input wire logic [63:0] pc,
   input wire logic isa_select,
   input wire logic redirect,
   input wire logic [63:0] redirect_pc,
   input wire logic pc_write,
   input wire logic [63:0] pc_write_val,
   output logic [63:0] pc_nxt
);
   function automatic logic [63:0] step(input logic isa);
      step = (isa == pcst_pkg::ISA_COMP16) ? pcst_pkg::PC_STEP_16
                                           : pcst_pkg::PC_STEP_32;
   endfunction : step

   always_comb begin
      if (redirect) begin
         pc_nxt = redirect_pc;
      end else if (pc_write) begin
         pc_nxt = pc_write_val;
      end else begin
         pc_nxt = pc + step(isa_select);
      end
   end
endmodule : pcst_pc_next
`default_nettype wire

// ---- logic/pcst_core_state.sv ----
// Purpose: Load/store byte order, link reservation, slot sequencing and PC.
// Assumes: INSN_ADV marks the end of one instruction slot.
// Notes: Slot effects land together when INSN_ADV is high; ATOMIC_BREAK and EXC_SAVE act in any cycle.
`timescale 1ns/1ps
`default_nettype none
module pcst_core_state (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic MEM_ORDER_STRAP,
   input wire logic USER_ORDER_FLIP_BIT,
   input wire logic USER_MODE,
   input wire logic ISA_SELECT,
   input wire logic INSN_ADV,
   input wire logic LINKED_LOAD,
   input wire logic COND_STORE,
   input wire logic ATOMIC_BREAK,
   input wire logic EXC_RETURN,
   input wire logic BRANCH_TAKEN,
   input wire logic [63:0] BRANCH_TARGET,
   input wire logic PC_WRITE,
   input wire logic [63:0] PC_WRITE_VAL,
   input wire logic LINK_SAVE,
   input wire logic EXC_SAVE,
   input wire logic RES_WR,
   input wire logic RES_DELAYED,
   input wire logic [4:0] RES_REG,
   input wire logic [63:0] RES_DATA,
   output logic [63:0] FETCH_PC,
   output logic EFFECTIVE_LOAD_STORE_ORDER,
   output logic MEMORY_BYTE_ORDER,
   output logic USER_ORDER_FLIP,
   output logic LINK_RESERVATION_FLAG,
   output logic COND_STORE_OK,
   output logic GPR_WR,
   output logic [4:0] GPR_WR_REG,
   output logic [63:0] GPR_WR_DATA,
   output logic EXC_PC_WR,
   output logic [63:0] EXC_PC_DATA
);
   logic [63:0] pc_r;
   logic [63:0] pc_nxt;
   logic [63:0] target_r;
   pcst_pkg::pcst_br_state_t br_r;
   logic mem_order_r;
   logic strap_taken_r;
   logic flip_r;
   logic eff_r;
   logic flag;
   logic store_ok;
   logic ok_r;
   logic flag_r;
   logic dly_wr_r;
   logic [4:0] dly_reg_r;
   logic [63:0] dly_data_r;
   logic gpr_wr_r;
   logic [4:0] gpr_reg_r;
   logic [63:0] gpr_data_r;
   logic exc_wr_r;
   logic [63:0] exc_data_r;
   logic redirect;
   logic [63:0] restart;
   localparam logic [4:0] LINK_REG = 5'h1f;
   pcst_pkg::pcst_br_state_t br_nxt;
   logic [63:0] target_nxt;
   logic mem_order_nxt;
   logic strap_taken_nxt;
   logic flip_nxt;
   logic eff_nxt;
   logic ok_nxt;
   logic flag_nxt;
   logic dly_wr_nxt;
   logic [4:0] dly_reg_nxt;
   logic [63:0] dly_data_nxt;
   logic gpr_wr_nxt;
   logic [4:0] gpr_reg_nxt;
   logic [63:0] gpr_data_nxt;
   logic exc_wr_nxt;
   logic [63:0] exc_data_nxt;
   logic slot_set;
   logic slot_clear;

   function automatic logic [63:0] restart_word(input logic [63:0] pc,
                                                input logic isa);
      restart_word = {pc[63:1], isa};
   endfunction : restart_word

   function automatic logic order_flip(input logic rev_bit,
                                       input logic user);
      order_flip = rev_bit & user;
   endfunction : order_flip

   // A link jump restarts past itself and its delay slot.
   function automatic logic [63:0] link_restart(input logic [63:0] pc,
                                                input logic isa);
      logic [63:0] step;
      step = (isa == pcst_pkg::ISA_COMP16) ? pcst_pkg::PC_STEP_16
                                           : pcst_pkg::PC_STEP_32;
      link_restart = restart_word(pc + step + step, isa);
   endfunction : link_restart

   // Memory order is caught once, in the first clocked cycle after reset.
   always_comb begin
      mem_order_nxt = mem_order_r;
      strap_taken_nxt = 1'b1;
      if (!strap_taken_r) begin
         mem_order_nxt = MEM_ORDER_STRAP;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         mem_order_r <= pcst_pkg::ORDER_LITTLE;
      end else begin
         mem_order_r <= mem_order_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         strap_taken_r <= 1'b0;
      end else begin
         strap_taken_r <= strap_taken_nxt;
      end
   end

   // Until the strap is caught, the live strap stands in for it.
   always_comb begin
      flip_nxt = order_flip(USER_ORDER_FLIP_BIT, USER_MODE);
      if (strap_taken_r) begin
         eff_nxt = mem_order_r ^ flip_nxt;
      end else begin
         eff_nxt = MEM_ORDER_STRAP ^ flip_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         flip_r <= 1'b0;
      end else begin
         flip_r <= flip_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         eff_r <= pcst_pkg::ORDER_LITTLE;
      end else begin
         eff_r <= eff_nxt;
      end
   end

   assign slot_set = LINKED_LOAD & INSN_ADV;
   assign slot_clear = ATOMIC_BREAK | (INSN_ADV & (EXC_RETURN | COND_STORE));

   pcst_link_flag u_link (
      .clk(CORE_CLK),
      .rst(RST),
      .linked_load(slot_set),
      .cond_store(COND_STORE & INSN_ADV),
      .atomic_break(ATOMIC_BREAK),
      .exc_return(EXC_RETURN & INSN_ADV),
      .flag(flag),
      .store_ok(store_ok)
   );

   // The visible flag mirrors the flag inside the reservation block.
   always_comb begin
      ok_nxt = store_ok;
      flag_nxt = flag;
      if (slot_clear) begin
         flag_nxt = 1'b0;
      end
      if (slot_set) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ok_r <= 1'b0;
         flag_r <= 1'b0;
      end else begin
         ok_r <= ok_nxt;
         flag_r <= flag_nxt;
      end
   end

   // Branch: taken in slot I, redirect applied at end of slot I+1.
   always_comb begin
      br_nxt = br_r;
      target_nxt = target_r;
      if (INSN_ADV) begin
         case (br_r)
            pcst_pkg::BR_IDLE: begin
               if (BRANCH_TAKEN) begin
                  br_nxt = pcst_pkg::BR_SLOT;
                  target_nxt = BRANCH_TARGET;
               end
            end
            pcst_pkg::BR_SLOT: begin
               br_nxt = pcst_pkg::BR_IDLE;
            end
            default: begin
               br_nxt = pcst_pkg::BR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         br_r <= pcst_pkg::BR_IDLE;
         target_r <= pcst_pkg::PC_RESET;
      end else begin
         br_r <= br_nxt;
         target_r <= target_nxt;
      end
   end

   assign redirect = (br_r == pcst_pkg::BR_SLOT);

   pcst_pc_next u_next (
      .pc(pc_r),
      .isa_select(ISA_SELECT),
      .redirect(redirect),
      .redirect_pc(target_r),
      .pc_write(PC_WRITE),
      .pc_write_val(PC_WRITE_VAL),
      .pc_nxt(pc_nxt)
   );

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         pc_r <= pcst_pkg::PC_RESET;
      end else if (INSN_ADV) begin
         pc_r <= pc_nxt;
      end
   end

   assign restart = link_restart(pc_r, ISA_SELECT);

   // Delayed results are held one slot and merged with the next slot.
   always_comb begin
      dly_wr_nxt = dly_wr_r;
      dly_reg_nxt = dly_reg_r;
      dly_data_nxt = dly_data_r;
      if (INSN_ADV) begin
         dly_wr_nxt = RES_WR & RES_DELAYED;
         dly_reg_nxt = RES_REG;
         dly_data_nxt = RES_DATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         dly_wr_r <= 1'b0;
      end else begin
         dly_wr_r <= dly_wr_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         dly_reg_r <= 5'h00;
         dly_data_r <= 64'h0;
      end else begin
         dly_reg_r <= dly_reg_nxt;
         dly_data_r <= dly_data_nxt;
      end
   end

   // One write per slot: link, then immediate, then a delayed result.
   // A delayed result that meets another write in its slot is lost.
   always_comb begin
      gpr_wr_nxt = 1'b0;
      gpr_reg_nxt = gpr_reg_r;
      gpr_data_nxt = gpr_data_r;
      if (INSN_ADV) begin
         if (LINK_SAVE) begin
            gpr_wr_nxt = 1'b1;
            gpr_reg_nxt = LINK_REG;
            gpr_data_nxt = restart;
         end else if (RES_WR && !RES_DELAYED) begin
            gpr_wr_nxt = 1'b1;
            gpr_reg_nxt = RES_REG;
            gpr_data_nxt = RES_DATA;
         end else if (dly_wr_r) begin
            gpr_wr_nxt = 1'b1;
            gpr_reg_nxt = dly_reg_r;
            gpr_data_nxt = dly_data_r;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         gpr_wr_r <= 1'b0;
      end else begin
         gpr_wr_r <= gpr_wr_nxt;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         gpr_reg_r <= 5'h00;
         gpr_data_r <= 64'h0;
      end else begin
         gpr_reg_r <= gpr_reg_nxt;
         gpr_data_r <= gpr_data_nxt;
      end
   end

   always_comb begin
      exc_wr_nxt = EXC_SAVE;
      exc_data_nxt = exc_data_r;
      if (EXC_SAVE) begin
         exc_data_nxt = restart_word(pc_r, ISA_SELECT);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         exc_wr_r <= 1'b0;
         exc_data_r <= 64'h0;
      end else begin
         exc_wr_r <= exc_wr_nxt;
         exc_data_r <= exc_data_nxt;
      end
   end

   assign FETCH_PC = pc_r;
   assign EFFECTIVE_LOAD_STORE_ORDER = eff_r;
   assign MEMORY_BYTE_ORDER = mem_order_r;
   assign USER_ORDER_FLIP = flip_r;
   assign LINK_RESERVATION_FLAG = flag_r;
   assign COND_STORE_OK = ok_r;
   assign GPR_WR = gpr_wr_r;
   assign GPR_WR_REG = gpr_reg_r;
   assign GPR_WR_DATA = gpr_data_r;
   assign EXC_PC_WR = exc_wr_r;
   assign EXC_PC_DATA = exc_data_r;
endmodule : pcst_core_state
`default_nettype wire

// ---- sim/pcst_fetch_model.sv ----
// Purpose: Fetch side model that ends instruction slots.
// Assumes: One clock; the bench asks for a slot end with req.
// Notes: Slow mode ends the slot one cycle late.
`timescale 1ns/1ps
`default_nettype none
module pcst_fetch_model (
   input wire logic clk,
   input wire logic req,
   input wire logic slow,
   input wire logic [63:0] pc,
   output logic adv,
   output logic [63:0] last_pc
);
   logic req_r;
   always_ff @(posedge clk) begin
      req_r <= req;
   end
   assign adv = slow ? req_r : req;
   always_ff @(posedge clk) begin
      if (adv)
         last_pc <= pc;
   end
endmodule : pcst_fetch_model
`default_nettype wire

// ---- sim/pcst_core_state_assertions.sv ----
// Purpose: Port checker for the processor state block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the processor state block above.
`timescale 1ns/1ps
`default_nettype none
module pcst_core_state_chk (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic USER_ORDER_FLIP_BIT,
   input wire logic USER_MODE,
   input wire logic ISA_SELECT,
   input wire logic INSN_ADV,
   input wire logic LINKED_LOAD,
   input wire logic COND_STORE,
   input wire logic ATOMIC_BREAK,
   input wire logic BRANCH_TAKEN,
   input wire logic [63:0] BRANCH_TARGET,
   input wire logic PC_WRITE,
   input wire logic [63:0] FETCH_PC,
   input wire logic EFFECTIVE_LOAD_STORE_ORDER,
   input wire logic MEMORY_BYTE_ORDER,
   input wire logic USER_ORDER_FLIP,
   input wire logic LINK_RESERVATION_FLAG,
   input wire logic COND_STORE_OK
);
   logic pend_r;
   logic [63:0] tgt_r;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   // Tracks the delay slot of a taken branch.
   always_ff @(posedge CORE_CLK) begin
      if (RST)
         pend_r <= 1'h0;
      else if (INSN_ADV)
         pend_r <= BRANCH_TAKEN & !pend_r;
   end
   always_ff @(posedge CORE_CLK) begin
      if (INSN_ADV & BRANCH_TAKEN & !pend_r)
         tgt_r <= BRANCH_TARGET;
   end
   chk_flip_user: assert property (!$past(RST) |->
      USER_ORDER_FLIP == $past(USER_ORDER_FLIP_BIT & USER_MODE))
      else $error("order flip wrong");
   chk_eff_xor: assert property (!$past(RST) && !$past(RST, 2) |->
      EFFECTIVE_LOAD_STORE_ORDER == (MEMORY_BYTE_ORDER ^ USER_ORDER_FLIP))
      else $error("effective order wrong");
   chk_order_held: assert property (!$past(RST) && !$past(RST, 2) |->
      $stable(MEMORY_BYTE_ORDER)) else $error("memory order moved");
   chk_ll_set: assert property (INSN_ADV && LINKED_LOAD |=>
      LINK_RESERVATION_FLAG) else $error("flag not set");
   chk_brk_clr: assert property (ATOMIC_BREAK && !(INSN_ADV && LINKED_LOAD)
      |=> !LINK_RESERVATION_FLAG) else $error("flag not cleared");
   chk_sc_ok: assert property (!$past(RST) |-> COND_STORE_OK ==
      $past(INSN_ADV & COND_STORE & LINK_RESERVATION_FLAG))
      else $error("store result wrong");
   chk_pc_step: assert property (INSN_ADV && !PC_WRITE && !pend_r |=>
      FETCH_PC == $past(FETCH_PC) + ($past(ISA_SELECT) ? 64'h2 : 64'h4))
      else $error("pc step wrong");
   chk_br_slot: assert property (INSN_ADV && pend_r |=>
      FETCH_PC == tgt_r) else $error("branch target wrong");
   cover property (INSN_ADV && pend_r);
   cover property (COND_STORE_OK);
   cover property (USER_ORDER_FLIP);
endmodule : pcst_core_state_chk
bind pcst_core_state pcst_core_state_chk i_chk (.*);
`default_nettype wire

// ---- sim/pcst_core_state_tb.sv ----
// Purpose: Self-checking bench for the processor state block.
// Assumes: Slot inputs are held for the one cycle of INSN_ADV.
// Notes: The fetch model ends each slot.
`timescale 1ns/1ps
`default_nettype none
module pcst_core_state_tb;
   logic [63:0] BRANCH_TARGET = 64'hfedc_ba98_7654_3210;
   logic [63:0] PC_WRITE_VAL = 64'h8000_0000_0000_1000;
   logic [4:0] RES_REG = 5'h0a;
   logic [63:0] RES_DATA = 64'h0123_4567_89ab_cdef;
   localparam logic [9:0] LL = 10'h200, CS = 10'h100, AB = 10'h080;
   localparam logic [9:0] ER = 10'h040, BR = 10'h020, PW = 10'h010;
   localparam logic [9:0] LS = 10'h008, ES = 10'h004, RW = 10'h002;
   localparam logic [9:0] RD = 10'h001;
   logic CORE_CLK = 1'h0;
   logic RST = 1'h1;
   logic MEM_ORDER_STRAP = 1'h0;
   logic USER_ORDER_FLIP_BIT = 1'h0;
   logic USER_MODE = 1'h0;
   logic ISA_SELECT = 1'h0;
   logic req = 1'h0;
   logic [9:0] k = 10'h0;
   wire INSN_ADV;
   logic [63:0] FETCH_PC, GPR_WR_DATA, EXC_PC_DATA;
   logic EFFECTIVE_LOAD_STORE_ORDER, MEMORY_BYTE_ORDER, USER_ORDER_FLIP;
   logic LINK_RESERVATION_FLAG, COND_STORE_OK, GPR_WR, EXC_PC_WR;
   logic [4:0] GPR_WR_REG;
   int n_errors = 0;
   int checks_done = 0;
   always #5 CORE_CLK = ~CORE_CLK;
   pcst_fetch_model i_mem (.clk(CORE_CLK), .req(req), .slow(1'h0),
      .pc(FETCH_PC), .adv(INSN_ADV), .last_pc());
   pcst_core_state i_dut (.LINKED_LOAD(k[9]), .COND_STORE(k[8]),
      .ATOMIC_BREAK(k[7]), .EXC_RETURN(k[6]), .BRANCH_TAKEN(k[5]),
      .PC_WRITE(k[4]), .LINK_SAVE(k[3]), .EXC_SAVE(k[2]), .RES_WR(k[1]),
      .RES_DELAYED(k[0]), .*);
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic slot(input logic [9:0] v);
      @(posedge CORE_CLK);
      k <= v;
      req <= 1'h1;
      @(posedge CORE_CLK);
      k <= 10'h0;
      req <= 1'h0;
      #1;
   endtask : slot
   task automatic do_reset(input logic s);
      @(posedge CORE_CLK);
      RST <= 1'h1;
      MEM_ORDER_STRAP <= s;
      repeat (12) @(posedge CORE_CLK);
      RST <= 1'h0;
      repeat (2) @(posedge CORE_CLK);
      MEM_ORDER_STRAP <= !s;
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk(MEMORY_BYTE_ORDER, s);
   endtask : do_reset
   task automatic t_order(input logic s);
      for (int i = 0; i < 4; i++) begin
         @(posedge CORE_CLK);
         {USER_ORDER_FLIP_BIT, USER_MODE} <= i[1:0];
         repeat (2) @(posedge CORE_CLK);
         #1;
         chk(USER_ORDER_FLIP, i == 3);
         chk(EFFECTIVE_LOAD_STORE_ORDER, s ^ (i == 3));
      end
   endtask : t_order
   task automatic t_link;
      slot(LL);
      chk(LINK_RESERVATION_FLAG, 1'h1);
      slot(CS);
      chk(COND_STORE_OK, 1'h1);
      slot(CS);
      chk(COND_STORE_OK, 1'h0);
      slot(LL);
      slot(AB);
      chk(LINK_RESERVATION_FLAG, 1'h0);
      slot(LL);
      slot(ER);
      chk(LINK_RESERVATION_FLAG, 1'h0);
      slot(CS);
      chk(COND_STORE_OK, 1'h0);
   endtask : t_link
   task automatic t_pc;
      logic [63:0] p;
      for (int i = 0; i < 3; i++) begin
         @(posedge CORE_CLK);
         ISA_SELECT <= (i == 1);
         #1;
         p = FETCH_PC;
         slot(10'h0);
         chk(FETCH_PC, p + ((i == 1) ? 64'h2 : 64'h4));
      end
      p = FETCH_PC;
      slot(BR);
      chk(FETCH_PC, p + 64'h4);
      slot(BR);
      chk(FETCH_PC, BRANCH_TARGET);
      slot(PW);
      chk(FETCH_PC, PC_WRITE_VAL);
      slot(10'h0);
      chk(i_mem.last_pc, PC_WRITE_VAL);
   endtask : t_pc
   task automatic t_res;
      logic [63:0] p;
      slot(RW);
      chk(GPR_WR, 1'h1);
      chk(GPR_WR_REG, RES_REG);
      chk(GPR_WR_DATA, RES_DATA);
      slot(RW | RD);
      chk(GPR_WR, 1'h0);
      slot(10'h0);
      chk(GPR_WR, 1'h1);
      chk(GPR_WR_REG, RES_REG);
      chk(GPR_WR_DATA, RES_DATA);
      p = FETCH_PC + 64'h8;
      slot(LS);
      chk(GPR_WR_REG, 5'h1f);
      chk(GPR_WR_DATA, {p[63:1], ISA_SELECT});
      p = FETCH_PC;
      slot(ES);
      chk(EXC_PC_WR, 1'h1);
      chk(EXC_PC_DATA, {p[63:1], ISA_SELECT});
   endtask : t_res
   initial begin
      do_reset(1'h1);
      t_order(1'h1);
      do_reset(1'h0);
      t_order(1'h0);
      t_link;
      t_pc;
      t_res;
      end_sim;
   end
   initial begin
      repeat (5000) @(posedge CORE_CLK);
      n_errors++;
      end_sim;
   end
endmodule : pcst_core_state_tb
`default_nettype wire
